// ### rtl/watch_timer.v
// watch timer and interval timer with one 8-bit mode register
`timescale 1ns/1ps
`include "watch_timer_map.vh"

module watch_timer #(
  parameter PRS_DIV = 128
) (
  // clock and reset
  input  wire       clk,
  input  wire       nrst,
  // register port
  input  wire [15:0] addr,
  input  wire        wr_byte,
  input  wire        wr_bit,
  input  wire [2:0]  bit_pos,
  input  wire [7:0]  wdata,
  output reg  [7:0]  rdata_ff,
  // subsystem clock tick, one cycle per subsystem edge
  input  wire        sub_tick,
  // interrupt requests
  output reg         watch_tick_irq,
  output reg         interval_tick_irq
);

  reg  [7:0]                    watch_mode_reg;
  reg  [7:0]                    nxt_mode;
  reg  [6:0]                    div_ff;
  reg  [`PRESCALER_WIDTH-1:0]   pre_ff;
  reg  [`COUNTER_WIDTH-1:0]     cnt_ff;
  wire                          run_en;
  wire                          cnt_en;
  wire                          prs_tick;
  wire                          fw_tick;
  wire [`PRESCALER_WIDTH-1:0]   nxt_pre;
  wire [`COUNTER_WIDTH-1:0]     nxt_cnt;
  wire                          pre_wrap9;
  wire                          cnt_step;
  wire                          sel;

  assign sel = (addr == `WATCH_MODE_ADDR);

  ////////////////////////////////////////////////////////////////////////
  // mode register
  always @* begin
    nxt_mode = watch_mode_reg;
    if (sel && wr_byte) begin
      nxt_mode = wdata;
    end else if (sel && wr_bit) begin
      nxt_mode[bit_pos] = wdata[0];
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watch_mode_reg <= `WATCH_MODE_RESET;
    end else begin
      watch_mode_reg <= nxt_mode;
    end
  end

  // read path shows zero off address, so a shared read bus can or it
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= sel ? watch_mode_reg : 8'h00;
    end
  end

  assign run_en = watch_mode_reg[`RUN_ENABLE_BIT];
  assign cnt_en = run_en & watch_mode_reg[`COUNTER_START_BIT];

  ////////////////////////////////////////////////////////////////////////
  // watch count clock enable
  // source select
  assign prs_tick = (div_ff == PRS_DIV[6:0] - 7'h01);
  assign fw_tick  = watch_mode_reg[`CLOCK_SOURCE_SELECT] ? sub_tick
                                                         : prs_tick;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= 7'h00;
    end else if (prs_tick) begin
      div_ff <= 7'h00;
    end else begin
      div_ff <= div_ff + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler and 5-bit counter
  // one prescaler feeds both interrupt paths, so only the run enable
  // bit may clear it; the counter path must never touch it
  assign nxt_pre = pre_ff + 11'h001;
  assign nxt_cnt = cnt_ff + 5'h01;

  // low n+1 bits wrapping to zero close a 2^(n+1) watch clock period
  function carry;
    input [10:0] nxt;
    input [3:0]  n;
    reg   [10:0] mask;
    begin
      mask  = (11'h001 << (n + 4'd1)) - 11'h001;
      carry = ((nxt & mask) == 11'h000);
    end
  endfunction

  // interval code to the prescaler bit whose wrap closes the period
  function [3:0] tap_of;
    input [2:0] code;
    begin
      case (code)
        3'h0:    tap_of = 4'd3;
        3'h1:    tap_of = 4'd4;
        3'h2:    tap_of = 4'd5;
        3'h3:    tap_of = 4'd6;
        3'h4:    tap_of = 4'd7;
        // code 101 taken as 2^9, one step below code 110
        3'h5:    tap_of = 4'd8;
        3'h6:    tap_of = 4'd9;
        default: tap_of = 4'd10;
      endcase
    end
  endfunction

  // watch period code to the wrap that closes a watch period
  function watch_end;
    input [1:0]  code;
    input        wrap9;
    input [4:0]  cnt;
    input [10:0] nxt;
    begin
      case (code)
        // 2^14: all 32 counter steps of 2^9
        2'h0:    watch_end = wrap9 && (cnt == 5'h1F);
        // 2^13: low four counter bits wrap, every 16 steps
        2'h1:    watch_end = wrap9 && (cnt[3:0] == 4'hF);
        // short periods come straight off the prescaler
        2'h2:    watch_end = carry(nxt, 4'd4);
        default: watch_end = carry(nxt, 4'd3);
      endcase
    end
  endfunction

  // counter steps on the 2^9 prescaler wrap
  assign pre_wrap9 = carry(nxt_pre, 4'd8);
  assign cnt_step  = fw_tick & pre_wrap9;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_ff <= 11'h000;
    end else if (!run_en) begin
      pre_ff <= 11'h000;
    end else if (fw_tick) begin
      pre_ff <= nxt_pre;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 5'h00;
    end else if (!cnt_en) begin
      cnt_ff <= 5'h00;
    end else if (cnt_step) begin
      // prescaler not cleared here, so first tick may be early
      cnt_ff <= nxt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // period decode
  // decode stays combinational so both pulses leave their flops one
  // cycle after the watch clock tick that closes the period
  reg  [3:0] itap;
  reg        it_hit;
  reg        wt_hit;

  always @* begin
    itap   = tap_of(watch_mode_reg[`TAP_SELECT_2:`TAP_SELECT_0]);
    it_hit = carry(nxt_pre, itap);
  end

  always @* begin
    wt_hit = watch_end(watch_mode_reg[`PERIOD_SELECT_HI:`PERIOD_SELECT_LO],
                       pre_wrap9, cnt_ff, nxt_pre);
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt pulses
  // a change of bits 7..4 while running shifts the next period; the
  // logic does not guard against it, software must stop first
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      watch_tick_irq    <= 1'b0;
      interval_tick_irq <= 1'b0;
    end else begin
      watch_tick_irq    <= cnt_en & fw_tick & wt_hit;
      interval_tick_irq <= run_en & fw_tick & it_hit;
    end
  end

endmodule

// ### rtl/watch_timer_map.vh
// register map, field positions and constants of the watch and interval timer
`ifndef WATCH_TIMER_MAP_VH
`define WATCH_TIMER_MAP_VH

`define WATCH_MODE_ADDR     16'hFF8F
`define WATCH_MODE_RESET    8'h00
`define RUN_ENABLE_BIT      0
`define COUNTER_START_BIT   1
`define PERIOD_SELECT_LO    2
`define PERIOD_SELECT_HI    3
`define TAP_SELECT_0        4
`define TAP_SELECT_2        6
`define CLOCK_SOURCE_SELECT 7
`define PRS_DIV_LOG2        7
`define PRESCALER_WIDTH     11
`define COUNTER_WIDTH       5
`define COUNTER_TAP         9

`endif

// ### testbench/tb_watch_timer.sv
// self-checking bench for the watch timer
`timescale 1ns/1ps
module tb_watch_timer;
  localparam int prs = 2;
  logic        clk, nrst, wr_byte, wr_bit, sub_tick;
  logic        watch_tick_irq, interval_tick_irq;
  logic [15:0] addr;
  logic [2:0]  bit_pos;
  logic [7:0]  wdata, rdata_ff, m;
  int          failures, compares, seed, r, i;
  watch_timer #(.PRS_DIV(prs)) DUT (.clk, .nrst, .addr, .wr_byte, .wr_bit,
    .bit_pos, .wdata, .rdata_ff, .sub_tick, .watch_tick_irq,
    .interval_tick_irq);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  function automatic int per(input logic [7:0] v, input bit w);
    return (v[7] ? 1 : prs) << (w ? (v[3] ? 5 : 14) - v[2] : v[6:4] + 4);
  endfunction
  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bit writes take the data bit from d[0] and the position from d[6:4]
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input bit b);
    addr    <= a;
    wdata   <= d;
    bit_pos <= d[6:4];
    wr_byte <= !b;
    wr_bit  <= b;
    @(posedge clk);
    wr_byte <= 0;
    wr_bit  <= 0;
    addr    <= 16'hFF8F;
    @(posedge clk);
  endtask
  task automatic wait_irq(input bit w);
    r = 0;
    do begin
      @(posedge clk);
      r++;
    end while ((w ? watch_tick_irq : interval_tick_irq) !== 1'b1
               && r < 40000);
    if (r >= 40000) begin
      failures++;
      tally_and_finish;
    end
  endtask
  // first period may be short, so time the second one
  task automatic period(input logic [7:0] v, input bit w);
    wait_irq(w);
    wait_irq(w);
    cmp(r, per(v, w));
  endtask
  initial begin
    seed = 32'h5ddd977e;
    {nrst, wr_byte, wr_bit, bit_pos, wdata} = 0;
    addr = 16'hFF8F;
    sub_tick = 1;
    repeat (5) @(posedge clk);
    nrst <= 1;
    wr(16'hFF80, 8'hFF, 0);
    cmp(rdata_ff, 8'h00);
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      m = {1'b0, i[2:0], r[3:1], 1'b1};
      wr(16'hFF8F, 8'h00, 0);
      wr(16'hFF8F, m, 0);
      period(m, 0);
      cmp(rdata_ff, m);
      $display("interval test %0d done", i);
    end
    for (i = 0; i < 4; i++) begin
      m = {2'b10, i[1:0], i[1:0], 2'b11};
      wr(16'hFF8F, 8'h00, 0);
      wr(16'hFF8F, m, 0);
      period(m, 1);
      $display("watch test %0d done", i);
    end
    wr(16'hFF8F, 8'h10, 1);
    period(8'hBD, 0);
    cmp(rdata_ff, 8'hBD);
    wr(16'hFF8F, 8'h11, 1);
    period(8'hBF, 1);
    wr(16'hFF8F, 8'h00, 0);
    repeat (20) @(posedge clk);
    $display("restart test done");
    tally_and_finish;
  end
endmodule

// ### testbench/watch_timer_props.sv
// port assertions for the watch timer
`timescale 1ns/1ps
module watch_timer_props #(
  parameter int PRS_DIV = 2
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [15:0] addr,
  input wire logic [7:0]  rdata_ff,
  input wire logic        watch_tick_irq,
  input wire logic        interval_tick_irq
);
  localparam int per16 = 16 * PRS_DIV;
  logic       ok_ff;
  wire        wt = watch_tick_irq;
  wire        it = interval_tick_irq;
  // mode is only visible after a cycle on its own address
  wire  [7:0] m  = ok_ff ? rdata_ff : 8'hFF;
  wire        i0 = m[7:4] == 4'h0 && m[0];
  wire        i4 = m[7:4] == 4'h8 && m[0];
  wire        w4 = m[7] && m[3:0] == 4'hF;
  wire        w5 = m[7] && m[3:0] == 4'hB;
  always @(posedge clk) ok_ff <= addr == 16'hFF8F;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_watch_one_pulse: assert property (wt |=> !wt)
    else $error("watch pulse long");
  a_ival_one_pulse: assert property (it |=> !it)
    else $error("interval pulse long");
  a_stop_quiet: assert property (!m[0] [*2] |-> !wt && !it)
    else $error("stopped but ticked");
  a_count_hold: assert property (!m[1] [*2] |-> !wt)
    else $error("held counter ticked");
  a_ival_div: assert property (it && i0 |-> ##per16 (it || !i0))
    else $error("divided interval off");
  a_ival_sub: assert property (it && i4 |-> ##16 (it || !i4))
    else $error("sub interval off");
  a_watch_p4: assert property (wt && w4 |-> ##16 (wt || !w4))
    else $error("watch period off");
  a_watch_p5: assert property (wt && w5 |-> ##32 (wt || !w5))
    else $error("watch period off");
endmodule
bind watch_timer watch_timer_props #(.PRS_DIV(PRS_DIV)) u_props (.clk, .nrst,
  .addr, .rdata_ff, .watch_tick_irq, .interval_tick_irq);
